// *** sfp_pkg.sv ***
/*
 sfp_pkg: constants and types for the serial flash mode and write-protect block.
 Assumes a 24-bit byte address into an 8 MB array and a 32-bit AHB-Lite register bus.
*/
package sfp_pkg;

   // ------------------------------------------------------------
   // command codes
   // ------------------------------------------------------------
   localparam logic [7:0] CMD_WRITE_ENABLE = 8'h06;
   localparam logic [7:0] CMD_WRITE_DISABLE = 8'h04;
   localparam logic [7:0] CMD_STATUS_WRITE = 8'h01;
   localparam logic [7:0] CMD_READ_STATUS = 8'h05;
   localparam logic [7:0] CMD_PAGE_PROGRAM = 8'h02;
   localparam logic [7:0] CMD_QUAD_PAGE_PROGRAM = 8'h32;
   localparam logic [7:0] CMD_SECTOR_ERASE = 8'h20;
   localparam logic [7:0] CMD_BLOCK32_ERASE = 8'h52;
   localparam logic [7:0] CMD_BLOCK64_ERASE = 8'hd8;
   localparam logic [7:0] CMD_CHIP_ERASE_A = 8'h60;
   localparam logic [7:0] CMD_CHIP_ERASE_B = 8'hc7;
   localparam logic [7:0] CMD_SECURITY_ERASE = 8'h44;
   localparam logic [7:0] CMD_SECURITY_PROGRAM = 8'h42;
   localparam logic [7:0] CMD_POWER_DOWN = 8'hb9;
   localparam logic [7:0] CMD_RELEASE = 8'hab;
   localparam logic [7:0] CMD_FOUR_LANE_ENTER = 8'h38;
   localparam logic [7:0] CMD_FOUR_LANE_EXIT = 8'hff;
   localparam logic [7:0] CMD_RESET_ENABLE = 8'h66;
   localparam logic [7:0] CMD_RESET = 8'h99;
   localparam logic [7:0] CMD_DUAL_OUT_READ = 8'h3b;
   localparam logic [7:0] CMD_DUAL_IO_READ = 8'hbb;
   localparam logic [7:0] CMD_QUAD_OUT_READ = 8'h6b;
   localparam logic [7:0] CMD_QUAD_IO_READ = 8'heb;
   localparam logic [7:0] CMD_QUAD_WORD_READ = 8'he7;

   // ------------------------------------------------------------
   // frame bit counts
   // ------------------------------------------------------------
   localparam logic [6:0] BITS_CMD_END = 7'h08;
   localparam logic [6:0] BITS_ADDR_END = 7'h20;
   localparam logic [6:0] BITS_DATA1_END = 7'h28;
   localparam logic [6:0] BITS_DATA2_END = 7'h30;
   localparam logic [6:0] BITS_STATUS1_END = 7'h10;
   localparam logic [6:0] BITS_STATUS2_END = 7'h18;
   localparam logic [6:0] BITS_MAX = 7'h78;

   // ------------------------------------------------------------
   // array geometry and protect decode
   // ------------------------------------------------------------
   localparam logic [23:0] ARRAY_LAST = 24'h7fffff;
   localparam logic [23:0] PROT_LARGE_UNIT = 24'h020000;
   localparam logic [23:0] PROT_SMALL_UNIT = 24'h001000;
   localparam logic [2:0] PROT_SMALL_CAP_CODE = 3'h4;
   localparam logic [2:0] PROT_SMALL_CAP_SHIFT = 3'h3;
   localparam logic [23:0] SPAN_PAGE = 24'h0000ff;
   localparam logic [23:0] SPAN_SECTOR = 24'h000fff;
   localparam logic [23:0] SPAN_BLOCK32 = 24'h007fff;
   localparam logic [23:0] SPAN_BLOCK64 = 24'h00ffff;

   // ------------------------------------------------------------
   // status word fields (as sent by a status write)
   // ------------------------------------------------------------
   localparam int SR_WEL_POS = 1;
   localparam int SR_BP_LSB = 2;
   localparam int SR_CMP_POS = 14;

   // ------------------------------------------------------------
   // register map (byte offsets) and fields
   // ------------------------------------------------------------
   localparam logic [7:0] OFF_STATE = 8'h00;
   localparam logic [7:0] OFF_PROTECT = 8'h04;
   localparam logic [7:0] OFF_READ_FILL = 8'h08;
   localparam logic [7:0] OFF_LAST_OP_CMD = 8'h0c;
   localparam logic [7:0] OFF_LAST_OP_ADDR = 8'h10;
   localparam int ST_WEL_POS = 0;
   localparam int ST_MODE_POS = 1;
   localparam int ST_DPD_POS = 2;
   localparam int ST_RSTEN_POS = 3;
   localparam int PROT_CMP_POS = 5;
   localparam logic [5:0] PROTECT_RESET = 6'h00;
   localparam logic [7:0] READ_FILL_RESET = 8'h00;

   // ------------------------------------------------------------
   // types
   // ------------------------------------------------------------
   typedef enum logic {SFP_MODE_SDQ = 1'b0, SFP_MODE_FOUR_LANE = 1'b1} sfp_mode_type;

   typedef struct packed {
      logic [7:0] cmd;
      logic [23:0] addr;
      logic [15:0] data;
      logic [6:0] bits;
   } sfp_frame_type;

   typedef struct packed {
      logic [7:0] cmd;
      logic [23:0] addr;
   } sfp_op_type;

   typedef struct packed {
      logic four_lane;
      logic [7:0] status;
      logic [7:0] fill;
   } sfp_snap_type;

endpackage

// *** sfp_top.sv ***
/*
 sfp_top: command mode, write-enable latch, power-down filter and block protection of a
 serial flash, with an AHB-Lite register slave.
 Ignores spi_clk edges while cs_n is high, and assumes the host holds cs_n high for at least
 four hclk periods between frames; array contents live outside, driven by op_valid/op.
*/
// Our own choices: the placing of the registers and the AHB-Lite interface to the registers.
`timescale 1ns/10ps
module sfp_top
(
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic [31:0] hrdata,
   output logic hreadyout,
   output logic hresp,
   input wire logic spi_clk,
   input wire logic cs_n,
   input wire logic [3:0] data_line_in,
   output logic [3:0] data_line_out,
   output logic [3:0] data_line_oe,
   output logic op_valid,
   output sfp_pkg::sfp_op_type op
);

   // ------------------------------------------------------------
   // helpers
   // ------------------------------------------------------------
   function automatic logic [2:0] lane_count(input logic four_lane, input logic [7:0] cmd,
                                             input logic [6:0] bits);
      lane_count = 3'h1;
      if (four_lane)
      begin
         lane_count = 3'h4;
      end
      else if (bits < sfp_pkg::BITS_CMD_END)
      begin
         lane_count = 3'h1;
      end
      else if (bits < sfp_pkg::BITS_ADDR_END)
      begin
         if (cmd == sfp_pkg::CMD_DUAL_IO_READ)
            lane_count = 3'h2;
         else if (cmd == sfp_pkg::CMD_QUAD_IO_READ || cmd == sfp_pkg::CMD_QUAD_WORD_READ)
            lane_count = 3'h4;
      end
      else
      begin
         if (cmd == sfp_pkg::CMD_DUAL_OUT_READ || cmd == sfp_pkg::CMD_DUAL_IO_READ)
            lane_count = 3'h2;
         else if (cmd == sfp_pkg::CMD_QUAD_OUT_READ || cmd == sfp_pkg::CMD_QUAD_IO_READ ||
                  cmd == sfp_pkg::CMD_QUAD_WORD_READ || cmd == sfp_pkg::CMD_QUAD_PAGE_PROGRAM)
            lane_count = 3'h4;
      end
   endfunction

   function automatic logic [23:0] shift_in(input logic [23:0] v, input logic [2:0] n,
                                            input logic [3:0] d);
      if (n == 3'h4)
         shift_in = {v[19:0], d};
      else if (n == 3'h2)
         shift_in = {v[21:0], d[1:0]};
      else
         shift_in = {v[22:0], d[0]};
   endfunction

   function automatic logic prot_hit(input logic [4:0] bp, input logic cmpb,
                                     input logic [23:0] lo, input logic [23:0] hi);
      logic [2:0] code;
      logic [23:0] size;
      logic [23:0] plo;
      logic [23:0] phi;
      code = bp[2:0];
      size = '0;
      plo = '0;
      phi = '0;
      // granularity from the highest protect bit
      if (!bp[4])
         size = sfp_pkg::PROT_LARGE_UNIT << (code - 3'h1);
      else if (code >= sfp_pkg::PROT_SMALL_CAP_CODE)
         size = sfp_pkg::PROT_SMALL_UNIT << sfp_pkg::PROT_SMALL_CAP_SHIFT;
      else
         size = sfp_pkg::PROT_SMALL_UNIT << (code - 3'h1);
      // complement protects the rest of the array outside the region
      if (!bp[3] && !cmpb)
      begin
         plo = sfp_pkg::ARRAY_LAST - size + 24'h000001;
         phi = sfp_pkg::ARRAY_LAST;
      end
      else if (bp[3] && !cmpb)
      begin
         plo = '0;
         phi = size - 24'h000001;
      end
      else if (!bp[3])
      begin
         plo = '0;
         phi = sfp_pkg::ARRAY_LAST - size;
      end
      else
      begin
         plo = size;
         phi = sfp_pkg::ARRAY_LAST;
      end
      if (code == 3'h0)
         prot_hit = cmpb;
      else if (code == 3'h7)
         prot_hit = !cmpb;
      else
         prot_hit = (lo <= phi) && (hi >= plo);
   endfunction

   // ------------------------------------------------------------
   // hclk-domain state shared with the link
   // ------------------------------------------------------------
   sfp_pkg::sfp_mode_type mode_r;
   logic wel_r;
   logic dpd_r;
   logic rsten_r;
   logic [5:0] prot_r;
   logic [7:0] fill_r;

   // ------------------------------------------------------------
   // link domain: spi_clk
   // ------------------------------------------------------------
   logic fresh_r;
   logic frame_tog_r;
   logic [6:0] bits_r;
   logic [7:0] cmd_r;
   logic [23:0] addr_r;
   logic [15:0] data_r;
   sfp_pkg::sfp_snap_type snap_r;
   logic fresh_rst;
   logic four_now;
   logic [6:0] cur_bits;
   logic [7:0] cur_cmd;
   logic [2:0] in_lanes;
   logic [6:0] bits_sum;
   logic [23:0] cmd_wide;
   logic [23:0] data_wide;

   assign fresh_rst = cs_n | ~hresetn;
   // mode and the latch are only changed while cs_n is high, so they are stable when the
   // first edge of a frame samples them; no synchroniser needed for these words
   assign four_now = fresh_r ? (mode_r == sfp_pkg::SFP_MODE_FOUR_LANE) : snap_r.four_lane;
   assign cur_bits = fresh_r ? 7'h00 : bits_r;
   assign cur_cmd = fresh_r ? 8'h00 : cmd_r;
   // command code over all four lanes in four-lane mode
   assign in_lanes = lane_count(four_now, cur_cmd, cur_bits);
   assign bits_sum = cur_bits + {4'h0, in_lanes};
   assign cmd_wide = shift_in({16'h0000, cur_cmd}, in_lanes, data_line_in);
   assign data_wide = shift_in({8'h00, data_r}, in_lanes, data_line_in);

   // frame start flag is preset asynchronously while deselected
   always_ff @(posedge spi_clk or posedge fresh_rst)
   begin
      if (fresh_rst)
         fresh_r <= 1'b1;
      else
         fresh_r <= 1'b0;
   end

   // capture on rising edge whatever the idle level was
   always_ff @(posedge spi_clk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         frame_tog_r <= 1'b0;
         bits_r <= '0;
         cmd_r <= '0;
         addr_r <= '0;
         data_r <= '0;
         snap_r <= '0;
      end
      // edges while deselected are ignored, so the idle level may change freely
      else if (!cs_n)
      begin
         if (fresh_r)
         begin
            frame_tog_r <= ~frame_tog_r;
            snap_r.four_lane <= (mode_r == sfp_pkg::SFP_MODE_FOUR_LANE);
            snap_r.status <= {1'b0, prot_r[4:0], wel_r, 1'b0};
            snap_r.fill <= fill_r;
            addr_r <= '0;
            data_r <= '0;
         end
         bits_r <= (bits_sum > sfp_pkg::BITS_MAX) ? sfp_pkg::BITS_MAX : bits_sum;
         if (cur_bits < sfp_pkg::BITS_CMD_END)
            cmd_r <= cmd_wide[7:0];
         else if (cur_bits < sfp_pkg::BITS_ADDR_END)
            addr_r <= shift_in(addr_r, in_lanes, data_line_in);
         else if (cur_bits < sfp_pkg::BITS_DATA2_END)
            data_r <= data_wide[15:0];
      end
   end

   // output lanes; read data and status go out on the falling edge
   logic [2:0] out_lanes;
   logic out_active;
   logic [7:0] out_src;
   logic [7:0] out_shift;
   assign out_lanes = lane_count(snap_r.four_lane, cmd_r, bits_r);
   assign out_shift = out_src << bits_r[2:0];

   always_comb
   begin
      out_active = 1'b0;
      out_src = snap_r.fill;
      if (!fresh_r && bits_r >= sfp_pkg::BITS_CMD_END && cmd_r == sfp_pkg::CMD_READ_STATUS)
      begin
         out_active = 1'b1;
         out_src = snap_r.status;
      end
      // array reads drive the fill byte once the address is in
      else if (!fresh_r && bits_r >= sfp_pkg::BITS_ADDR_END &&
               (cmd_r == sfp_pkg::CMD_DUAL_OUT_READ || cmd_r == sfp_pkg::CMD_DUAL_IO_READ ||
                cmd_r == sfp_pkg::CMD_QUAD_OUT_READ || cmd_r == sfp_pkg::CMD_QUAD_IO_READ ||
                cmd_r == sfp_pkg::CMD_QUAD_WORD_READ))
      begin
         out_active = 1'b1;
      end
   end

   // outputs change on the falling edge
   always_ff @(negedge spi_clk or posedge fresh_rst)
   begin
      if (fresh_rst)
      begin
         data_line_out <= '0;
         data_line_oe <= '0;
      end
      else if (!out_active)
      begin
         data_line_out <= '0;
         data_line_oe <= '0;
      end
      else if (out_lanes == 3'h4)
      begin
         data_line_out <= out_shift[7:4];
         data_line_oe <= 4'hf;
      end
      else if (out_lanes == 3'h2)
      begin
         data_line_out <= {2'h0, out_shift[7:6]};
         data_line_oe <= 4'h3;
      end
      else
      begin
         data_line_out <= {2'h0, out_shift[7], 1'b0};
         data_line_oe <= 4'h2;
      end
   end

   // ------------------------------------------------------------
   // frame end detection in hclk domain
   // ------------------------------------------------------------
   logic cs_meta_r;
   logic cs_sync_r;
   logic cs_prev_r;
   logic tog_meta_r;
   logic tog_sync_r;
   logic tog_seen_r;
   logic exec;
   sfp_pkg::sfp_frame_type frame;

   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         cs_meta_r <= 1'b1;
         cs_sync_r <= 1'b1;
         cs_prev_r <= 1'b1;
         tog_meta_r <= 1'b0;
         tog_sync_r <= 1'b0;
         tog_seen_r <= 1'b0;
      end
      else
      begin
         cs_meta_r <= cs_n;
         cs_sync_r <= cs_meta_r;
         cs_prev_r <= cs_sync_r;
         tog_meta_r <= frame_tog_r;
         tog_sync_r <= tog_meta_r;
         if (cs_sync_r && !cs_prev_r)
            tog_seen_r <= tog_sync_r;
      end
   end

   // frame fields are frozen once spi_clk stops with cs_n high
   assign frame = '{cmd: cmd_r, addr: addr_r, data: data_r, bits: bits_r};
   assign exec = cs_sync_r && !cs_prev_r && (tog_sync_r != tog_seen_r);

   // ------------------------------------------------------------
   // command decisions
   // ------------------------------------------------------------
   logic whole;
   logic awake;
   logic only_cmd;
   logic is_array;
   logic is_security;
   logic addr_ok;
   logic [23:0] op_span;
   logic [23:0] op_lo;
   logic [23:0] op_hi;
   logic hit;
   logic do_reset;
   logic do_status;
   logic do_op;
   logic write_try;

   always_comb
   begin
      whole = frame.bits >= sfp_pkg::BITS_CMD_END && frame.bits[2:0] == 3'h0;
      awake = !dpd_r;
      only_cmd = frame.bits == sfp_pkg::BITS_CMD_END;
      is_security = frame.cmd == sfp_pkg::CMD_SECURITY_ERASE ||
                    frame.cmd == sfp_pkg::CMD_SECURITY_PROGRAM;
      is_array = 1'b1;
      op_span = sfp_pkg::SPAN_PAGE;
      addr_ok = frame.bits == sfp_pkg::BITS_ADDR_END;
      if (frame.cmd == sfp_pkg::CMD_PAGE_PROGRAM || frame.cmd == sfp_pkg::CMD_QUAD_PAGE_PROGRAM)
         addr_ok = frame.bits >= sfp_pkg::BITS_DATA1_END;
      else if (frame.cmd == sfp_pkg::CMD_SECTOR_ERASE)
         op_span = sfp_pkg::SPAN_SECTOR;
      else if (frame.cmd == sfp_pkg::CMD_BLOCK32_ERASE)
         op_span = sfp_pkg::SPAN_BLOCK32;
      else if (frame.cmd == sfp_pkg::CMD_BLOCK64_ERASE)
         op_span = sfp_pkg::SPAN_BLOCK64;
      else if (frame.cmd == sfp_pkg::CMD_CHIP_ERASE_A || frame.cmd == sfp_pkg::CMD_CHIP_ERASE_B)
      begin
         op_span = sfp_pkg::ARRAY_LAST;
         addr_ok = only_cmd;
      end
      else if (is_security)
         addr_ok = frame.bits >= sfp_pkg::BITS_ADDR_END;
      else
         is_array = 1'b0;
      op_lo = frame.addr & ~op_span;
      op_hi = op_lo | op_span;
      // any targeted byte inside the protected region rejects the command, except security erase and program
      hit = prot_hit(prot_r[4:0], prot_r[sfp_pkg::PROT_CMP_POS], op_lo, op_hi);
      // only release and the reset pair get past power-down
      do_reset = exec && whole && only_cmd && frame.cmd == sfp_pkg::CMD_RESET && rsten_r;
      // writes need the latch
      // status bytes follow the command directly and ride in the address shifter
      do_status = exec && awake && whole && wel_r && frame.cmd == sfp_pkg::CMD_STATUS_WRITE &&
                  (frame.bits == sfp_pkg::BITS_STATUS1_END ||
                   frame.bits == sfp_pkg::BITS_STATUS2_END);
      do_op = exec && awake && whole && wel_r && is_array && addr_ok && (!hit || is_security);
      write_try = do_status || (exec && awake && whole && wel_r && is_array && addr_ok);
   end

   // ------------------------------------------------------------
   // mode, latch, power-down and reset-enable state
   // ------------------------------------------------------------
   // one mode at a time; enter/exit by command, reset back to default
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
         mode_r <= sfp_pkg::SFP_MODE_SDQ;
      else if (do_reset)
         mode_r <= sfp_pkg::SFP_MODE_SDQ;
      else if (exec && awake && whole && only_cmd && frame.cmd == sfp_pkg::CMD_FOUR_LANE_ENTER)
         mode_r <= sfp_pkg::SFP_MODE_FOUR_LANE;
      else if (exec && awake && whole && only_cmd && frame.cmd == sfp_pkg::CMD_FOUR_LANE_EXIT)
         mode_r <= sfp_pkg::SFP_MODE_SDQ;
   end

   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
         wel_r <= 1'b0;
      // clear on disable, reset, and every write attempt
      else if (do_reset || write_try ||
               (exec && awake && whole && only_cmd && frame.cmd == sfp_pkg::CMD_WRITE_DISABLE))
         wel_r <= 1'b0;
      else if (exec && awake && whole && only_cmd && frame.cmd == sfp_pkg::CMD_WRITE_ENABLE)
         wel_r <= 1'b1;
   end

   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         dpd_r <= 1'b0;
         rsten_r <= 1'b0;
      end
      else if (exec)
      begin
         // power-down entry and its two exits
         if (do_reset || (frame.cmd == sfp_pkg::CMD_RELEASE && frame.bits >= sfp_pkg::BITS_CMD_END))
            dpd_r <= 1'b0;
         else if (awake && whole && only_cmd && frame.cmd == sfp_pkg::CMD_POWER_DOWN)
            dpd_r <= 1'b1;
         rsten_r <= whole && only_cmd && frame.cmd == sfp_pkg::CMD_RESET_ENABLE;
      end
   end

   // ------------------------------------------------------------
   // operation strobe to the array
   // ------------------------------------------------------------
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         op_valid <= 1'b0;
         op <= '0;
      end
      else
      begin
         // only unprotected targets and security erase/program reach the array
         op_valid <= do_op;
         if (do_op)
            op <= '{cmd: frame.cmd, addr: op_lo};
      end
   end

   // ------------------------------------------------------------
   // AHB-Lite slave: zero wait states, always OKAY
   // ------------------------------------------------------------
   logic ph_write_r;
   logic [7:0] ph_addr_r;
   logic ph_take;

   assign hreadyout = 1'b1;
   assign hresp = 1'b0;
   assign ph_take = hsel && hready && htrans[1];

   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         ph_write_r <= 1'b0;
         ph_addr_r <= '0;
         hrdata <= '0;
      end
      else if (hready)
      begin
         ph_write_r <= ph_take && hwrite;
         ph_addr_r <= haddr[7:0];
         hrdata <= '0;
         if (ph_take && !hwrite)
         begin
            if (haddr[7:0] == sfp_pkg::OFF_STATE)
               hrdata <= {28'h0000000, rsten_r, dpd_r, mode_r == sfp_pkg::SFP_MODE_FOUR_LANE,
                          wel_r};
            else if (haddr[7:0] == sfp_pkg::OFF_PROTECT)
               hrdata <= {26'h0000000, prot_r};
            else if (haddr[7:0] == sfp_pkg::OFF_READ_FILL)
               hrdata <= {24'h000000, fill_r};
            else if (haddr[7:0] == sfp_pkg::OFF_LAST_OP_CMD)
               hrdata <= {24'h000000, op.cmd};
            else if (haddr[7:0] == sfp_pkg::OFF_LAST_OP_ADDR)
               hrdata <= {8'h00, op.addr};
         end
      end
   end

   // status write by the link wins over a bus write in the same cycle
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
         prot_r <= sfp_pkg::PROTECT_RESET;
      else if (do_status)
      begin
         // one byte sits in addr[7:0]; with two, the first moved up to addr[15:8]
         if (frame.bits == sfp_pkg::BITS_STATUS2_END)
         begin
            prot_r[4:0] <= frame.addr[8 + sfp_pkg::SR_BP_LSB +: 5];
            prot_r[sfp_pkg::PROT_CMP_POS] <= frame.addr[sfp_pkg::SR_CMP_POS - 8];
         end
         else
            prot_r[4:0] <= frame.addr[sfp_pkg::SR_BP_LSB +: 5];
      end
      else if (ph_write_r && ph_addr_r == sfp_pkg::OFF_PROTECT)
         prot_r <= hwdata[5:0];
   end

   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
         fill_r <= sfp_pkg::READ_FILL_RESET;
      else if (ph_write_r && ph_addr_r == sfp_pkg::OFF_READ_FILL)
         fill_r <= hwdata[7:0];
   end

endmodule

// *** sfp_chk_assertions.sv ***
/* sfp_chk: port checks bound into sfp_top.
 assumes the host keeps cs_n high for some hclk periods between frames. */
`timescale 1ns/10ps
module sfp_chk
(
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic cs_n,
   input wire logic hreadyout,
   input wire logic hresp,
   input wire logic op_valid,
   input wire logic [3:0] data_line_oe,
   input wire sfp_pkg::sfp_op_type op
);
   default clocking @(posedge hclk); endclocking
   default disable iff (!hresetn);
   // ---
   // port checks
   // ---
   a_idle_quiet: assert property (cs_n |-> data_line_oe == 4'h0) else $error("lanes driven");
   a_lane_shape: assert property (data_line_oe inside {4'h0, 4'h2, 4'h3, 4'hf})
      else $error("bad lane set");
   a_op_pulse: assert property (op_valid |=> !op_valid) else $error("op pulse long");
   a_op_steady: assert property ($changed(op) |-> op_valid) else $error("op moved");
   a_op_kind: assert property (op_valid |-> op.cmd inside
      {8'h02, 8'h32, 8'h20, 8'h52, 8'hd8, 8'h60, 8'hc7, 8'h44, 8'h42}) else $error("bad op");
   a_sector_align: assert property (op_valid && op.cmd == 8'h20 |-> op.addr[11:0] == 12'h0)
      else $error("sector unaligned");
   a_op_deselect: assert property (op_valid |-> $past(cs_n, 2)) else $error("op early");
   a_bus_okay: assert property (hreadyout && !hresp) else $error("bus stall");
   c_op: cover property (op_valid);
   c_quad: cover property (data_line_oe == 4'hf);
   c_dual: cover property (data_line_oe == 4'h3);
endmodule
bind sfp_top sfp_chk u_chk (.hclk, .hresetn, .cs_n, .hreadyout, .hresp, .op_valid,
   .data_line_oe, .op);

// *** sfp_host.sv ***
/* sfp_host: serial host model, clock mode 0 or 3, 160 ns link clock.
 assumes the bench sends one frame at a time. */
`timescale 1ns/10ps
module sfp_host
(
   output logic spi_clk,
   output logic cs_n,
   output logic [3:0] data_line_in,
   input logic [3:0] data_line_out
);
   logic [63:0] rx = 64'h0;
   logic [63:0] rx1 = 64'h0;
   initial
   begin
      spi_clk = 1'b0;
      cs_n = 1'b1;
      data_line_in = 4'h0;
   end
   // ---
   // frame send
   // ---
   // idle low, or high with m3; drive on fall
   task automatic send(input logic [63:0] v, input int n, input int w, input bit m3 = 1'b0);
      // idle level set first; offset keeps link edges off the bus clock edges
      spi_clk = m3;
      #7 cs_n <= 1'b0;
      for (int i = 0; i < n; i += w)
      begin
         data_line_in <= (w == 4) ? v[63:60] : {3'h0, v[63]};
         v = v << w;
         spi_clk = 1'b0;
         #80 spi_clk = 1'b1;
         rx = {rx[59:0], data_line_out};
         rx1 = {rx1[62:0], data_line_out[1]};
         #80;
      end
      spi_clk = m3;
      #80 cs_n <= 1'b1;
      // released lanes flip so a stale bit never matches
      data_line_in <= ~data_line_in;
      #400;
   endtask
endmodule

// *** sfp_top_bench.sv ***
/* sfp_top_bench: register and serial checks of sfp_top.
 assumes sfp_host on the serial side and one AHB-Lite slave. */
`timescale 1ns/10ps
module sfp_top_bench;
   logic hclk = 1'b0;
   logic hresetn = 1'b0;
   logic hsel = 1'b0;
   logic hwrite = 1'b0;
   logic [1:0] htrans = 2'h0;
   logic [31:0] haddr = 32'h0;
   logic [31:0] hwdata = 32'h0;
   logic [31:0] hrdata, q;
   logic hreadyout, hresp, op_valid, spi_clk, cs_n;
   logic [3:0] dli, dlo;
   sfp_pkg::sfp_op_type op;
   int err_count = 0;
   int check_count = 0;
   int ops = 0;
   int n = 0;
   // protect code, erase address, accepted
   logic [30:0] tbl [8] = '{{6'h00, 24'h123456, 1'b1}, {6'h01, 24'h7e0000, 1'b0},
      {6'h01, 24'h7df000, 1'b1}, {6'h21, 24'h7e0000, 1'b1}, {6'h21, 24'h000000, 1'b0},
      {6'h19, 24'h001000, 1'b1}, {6'h19, 24'h000fff, 1'b0}, {6'h07, 24'h400000, 1'b0}};
   sfp_top dut (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize(3'h2), .hwdata,
      .hready(hreadyout), .hrdata, .hreadyout, .hresp, .spi_clk, .cs_n, .data_line_in(dli),
      .data_line_out(dlo), .data_line_oe(), .op_valid, .op);
   sfp_host h (.spi_clk, .cs_n, .data_line_in(dli), .data_line_out(dlo));
   initial
   begin
      forever #20 hclk = ~hclk;
   end
   always @(posedge hclk) if (op_valid === 1'b1) ops <= ops + 1;
   // ---
   // tasks
   // ---
   task automatic chk(input string s, input logic [31:0] g, input logic [31:0] e);
      check_count++;
      if (g !== e)
      begin
         err_count++;
         $display("[ERR] %s exp %h got %h", s, e, g);
      end
   endtask
   task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge hclk);
      hsel <= 1'b1;
      haddr <= {24'h0, a};
      hwrite <= w;
      htrans <= 2'h2;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      htrans <= 2'h0;
      hsel <= 1'b0;
      hwdata <= d;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      q = hrdata;
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] e);
      bus(1'b0, a, 32'h0);
      chk("register", q, e);
   endtask
   task automatic cmd(input logic [7:0] c, input int w);
      h.send({c, 56'h0}, 8, w);
   endtask
   task automatic complete_run;
      if (err_count == 0 && check_count > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask
   initial
   begin
      #3000000;
      err_count++;
      complete_run;
   end
   // ---
   // tests
   // ---
   initial
   begin
      repeat (20) @(posedge hclk);
      hresetn <= 1'b1;
      repeat (2) @(posedge hclk);
      rd(sfp_pkg::OFF_STATE, 32'h0);
      rd(sfp_pkg::OFF_PROTECT, 32'h0);
      h.send({8'h20, 24'h010000, 32'h0}, 32, 1);
      chk("op count", ops, 0);
      cmd(8'h06, 1);
      rd(sfp_pkg::OFF_STATE, 32'h1);
      h.send({8'h04, 56'h0}, 8, 1, 1'b1);
      rd(sfp_pkg::OFF_STATE, 32'h0);
      cmd(8'h06, 1);
      h.send({8'h01, 8'h04, 48'h0}, 16, 1);
      rd(sfp_pkg::OFF_PROTECT, 32'h1);
      rd(sfp_pkg::OFF_STATE, 32'h0);
      h.send({8'h05, 56'h0}, 16, 1);
      chk("status out", h.rx1[7:0], 8'h04);
      for (int i = 0; i < 8; i++)
      begin
         bus(1'b1, sfp_pkg::OFF_PROTECT, {26'h0, tbl[i][30:25]});
         cmd(8'h06, 1);
         h.send({8'h20, tbl[i][24:1], 32'h0}, 32, 1);
         n += tbl[i][0];
         chk("op count", ops, n);
         if (tbl[i][0]) chk("op addr", {8'h0, op.addr}, {8'h0, tbl[i][24:13], 12'h0});
         rd(sfp_pkg::OFF_STATE, 32'h0);
      end
      cmd(8'h38, 1);
      rd(sfp_pkg::OFF_STATE, 32'h2);
      cmd(8'h06, 4);
      rd(sfp_pkg::OFF_STATE, 32'h3);
      cmd(8'hff, 4);
      rd(sfp_pkg::OFF_STATE, 32'h1);
      cmd(8'h38, 1);
      cmd(8'h66, 4);
      cmd(8'h99, 4);
      rd(sfp_pkg::OFF_STATE, 32'h0);
      cmd(8'hb9, 1);
      cmd(8'h06, 1);
      rd(sfp_pkg::OFF_STATE, 32'h4);
      cmd(8'hab, 1);
      rd(sfp_pkg::OFF_STATE, 32'h0);
      bus(1'b1, sfp_pkg::OFF_READ_FILL, 32'ha5);
      rd(sfp_pkg::OFF_READ_FILL, 32'ha5);
      h.send({8'h6b, 56'h0}, 48, 1);
      chk("quad out", h.rx[7:0], 8'ha5);
      h.send({8'h3b, 56'h0}, 48, 1);
      complete_run;
   end
endmodule
